// ---- rtl/pdrc_regs.v ----
// oscillator control and frequency ramp register bank for the first pll
// assumes a simple write/read strobe port from the serial configuration decoder
//
// Contract
// - ramp slope bits 5:4 pick 0.2, 2, 20 or 200 ppm/s.
// - ramp enable bit 3 turns ramping on; resets to zero.
// - ramp bits 2:0 hold the divider value exactly as written.
// - fractional code is four read-write bytes at 31h..34h, reset zero.
// - writing one to 35h bit 3 requests a frequency increase.
// - writing one to 35h bit 2 requests a frequency decrease.
// - 35h bit 1 enables free-run mode; resets to zero.
// - 35h bit 0 masks oscillator control; bits 7:4 reserved, reset zero.
// - integer code is 36h bits 7:0 plus 37h bits 7:6.
// - 37h bit 5 enables sync mode; bits 4:0 spare storage.
// - page select at FFh on every page, read-write, reset zero.
`timescale 1ns/1ps
`include "pdrc_defs.vh"

module pdrc_regs
(
    input  wire        I_CLK,
    input  wire        I_RST,
    input  wire        i_wr_en,
    input  wire        i_rd_en,
    input  wire [7:0]  i_addr,
    input  wire [7:0]  i_wdata,
    output reg  [7:0]  o_rdata,
    output wire [7:0]  o_page,
    output wire        o_ramp_en,
    output wire [1:0]  o_ramp_slope,
    output wire [2:0]  o_ramp_div,
    output wire [31:0] o_frac_code,
    output wire [9:0]  o_int_code,
    output wire        o_step_up,
    output wire        o_step_down,
    output wire        o_free_run,
    output wire        o_osc_mask,
    output wire        o_sync_mode
);

    // ****************************************
    // storage
    // ****************************************
    reg  [7:0]  ramp_q;
    reg  [7:0]  frac_q [0:3];
    reg  [7:0]  step_q;
    reg  [7:0]  int_lo_q;
    reg  [7:0]  int_hi_q;
    reg  [7:0]  page_q;
    reg         inc_pulse_q;
    reg         dec_pulse_q;
    wire        bank_open;
    wire        wr_page;
    wire        wr_ramp;
    wire [3:0]  wr_frac;
    wire        wr_step;
    wire        wr_int_lo;
    wire        wr_int_hi;
    wire        both_req;

    // ****************************************
    // write decode
    // ****************************************
    // page select answers on any page; the bank itself only on its own page
    assign bank_open = (page_q == `PDRC_BANK_PAGE);
    assign wr_page   = i_wr_en && (i_addr == `PDRC_OFF_PAGE);
    assign wr_ramp   = i_wr_en && bank_open && (i_addr == `PDRC_OFF_RAMP);
    assign wr_frac   = {4{i_wr_en && bank_open}} & {(i_addr == `PDRC_OFF_FRAC3),
                                                    (i_addr == `PDRC_OFF_FRAC2),
                                                    (i_addr == `PDRC_OFF_FRAC1),
                                                    (i_addr == `PDRC_OFF_FRAC0)};
    assign wr_step   = i_wr_en && bank_open && (i_addr == `PDRC_OFF_STEP);
    assign wr_int_lo = i_wr_en && bank_open && (i_addr == `PDRC_OFF_INT_LO);
    assign wr_int_hi = i_wr_en && bank_open && (i_addr == `PDRC_OFF_INT_HI);
    // both bits in one write cancel
    assign both_req  = i_wdata[`PDRC_STEP_INC_BIT] && i_wdata[`PDRC_STEP_DEC_BIT];

    // ****************************************
    // write side
    // ****************************************
    // page register
    always @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
            page_q <= `PDRC_RESET_VAL;
        else if (wr_page)
            page_q <= i_wdata;
    end

    always @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
            ramp_q <= `PDRC_RESET_VAL;
        else if (wr_ramp)
            ramp_q <= i_wdata & `PDRC_RAMP_WMASK;
    end

    // free run and mask; reserved bits stay zero
    // request bits kept so software reads back what it wrote
    always @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
            step_q <= `PDRC_RESET_VAL;
        else if (wr_step)
            step_q <= i_wdata & `PDRC_STEP_WMASK;
    end

    always @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
            int_lo_q <= `PDRC_RESET_VAL;
        else if (wr_int_lo)
            int_lo_q <= i_wdata;
    end

    // integer high bits, sync, spare storage
    always @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
            int_hi_q <= `PDRC_RESET_VAL;
        else if (wr_int_hi)
            int_hi_q <= i_wdata;
    end

    // four fractional bytes at consecutive offsets
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : g_frac
            always @(posedge I_CLK or posedge I_RST)
            begin
                if (I_RST)
                    frac_q[g] <= `PDRC_RESET_VAL;
                else if (wr_frac[g])
                    frac_q[g] <= i_wdata;
            end
            assign o_frac_code[8*g+7:8*g] = frac_q[g];
        end
    endgenerate

    // ****************************************
    // step requests
    // ****************************************
    // one pulse per write of one; both together give no change
    // a held level would step again every cycle, so only the write asks
    // increase request
    always @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
            inc_pulse_q <= `PDRC_PULSE_IDLE;
        else
            inc_pulse_q <= wr_step && i_wdata[`PDRC_STEP_INC_BIT] && !both_req;
    end

    always @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
            dec_pulse_q <= `PDRC_PULSE_IDLE;
        else
            dec_pulse_q <= wr_step && i_wdata[`PDRC_STEP_DEC_BIT] && !both_req;
    end

    // ****************************************
    // read side
    // ****************************************
    always @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
            o_rdata <= `PDRC_RESET_VAL;
        else if (i_rd_en)
        begin
            if (i_addr == `PDRC_OFF_PAGE)
                o_rdata <= page_q;
            else if (!bank_open)
                o_rdata <= `PDRC_IDLE_READ;
            else
            begin
                case (i_addr)
                    `PDRC_OFF_RAMP:   o_rdata <= ramp_q;
                    `PDRC_OFF_FRAC0:  o_rdata <= frac_q[0];
                    `PDRC_OFF_FRAC1:  o_rdata <= frac_q[1];
                    `PDRC_OFF_FRAC2:  o_rdata <= frac_q[2];
                    `PDRC_OFF_FRAC3:  o_rdata <= frac_q[3];
                    `PDRC_OFF_STEP:   o_rdata <= step_q;
                    `PDRC_OFF_INT_LO: o_rdata <= int_lo_q;
                    `PDRC_OFF_INT_HI: o_rdata <= int_hi_q;
                    default:          o_rdata <= `PDRC_IDLE_READ;
                endcase
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // active page
    assign o_page       = page_q;
    // ramp active only while bit set
    assign o_ramp_en    = ramp_q[`PDRC_RAMP_EN_BIT];
    // slope code to the ramp engine
    assign o_ramp_slope = ramp_q[`PDRC_RAMP_SLOPE_HI:`PDRC_RAMP_SLOPE_LO];
    assign o_ramp_div   = ramp_q[`PDRC_RAMP_DIV_HI:`PDRC_RAMP_DIV_LO];
    assign o_int_code   = {int_lo_q, int_hi_q[`PDRC_INT_HI_MSB:`PDRC_INT_HI_LSB]};
    assign o_step_up    = inc_pulse_q;
    assign o_step_down  = dec_pulse_q;
    assign o_free_run   = step_q[`PDRC_STEP_FREE_BIT];
    assign o_osc_mask   = step_q[`PDRC_STEP_MASK_BIT];
    assign o_sync_mode  = int_hi_q[`PDRC_SYNC_BIT];

endmodule // pdrc_regs

// ---- rtl/pdrc_defs.vh ----
// register offsets, field positions and reset values for the oscillator/ramp bank
// assumes an 8-bit offset space reached by the configuration port
`ifndef PDRC_DEFS_VH
`define PDRC_DEFS_VH
`define PDRC_OFF_RAMP       8'h30
`define PDRC_OFF_FRAC0      8'h31
`define PDRC_OFF_FRAC1      8'h32
`define PDRC_OFF_FRAC2      8'h33
`define PDRC_OFF_FRAC3      8'h34
`define PDRC_OFF_STEP       8'h35
`define PDRC_OFF_INT_LO     8'h36
`define PDRC_OFF_INT_HI     8'h37
`define PDRC_OFF_PAGE       8'hFF
`define PDRC_RAMP_SLOPE_HI  5
`define PDRC_RAMP_SLOPE_LO  4
`define PDRC_RAMP_EN_BIT    3
`define PDRC_RAMP_DIV_HI    2
`define PDRC_STEP_INC_BIT   3
`define PDRC_STEP_DEC_BIT   2
`define PDRC_STEP_FREE_BIT  1
`define PDRC_STEP_MASK_BIT  0
`define PDRC_INT_HI_MSB     7
`define PDRC_INT_HI_LSB     6
`define PDRC_SYNC_BIT       5
`define PDRC_SPARE_HI       4
`define PDRC_RESET_VAL      8'h00
`define PDRC_PULSE_IDLE     1'h0
`define PDRC_BANK_PAGE      8'h00
`define PDRC_IDLE_READ      8'h00
`define PDRC_RAMP_WMASK     8'h3F
`define PDRC_STEP_WMASK     8'h0F
`define PDRC_RAMP_DIV_LO    0
`define PDRC_SLOPE_0P2      2'h0
`define PDRC_SLOPE_2        2'h1
`define PDRC_SLOPE_20       2'h2
`define PDRC_SLOPE_200      2'h3
`endif

// ---- sim/pdrc_checker.sv ----
// assertions on the oscillator and ramp bank ports
// bound to pdrc_regs from the bench top file
`timescale 1ns/1ps
module pdrc_chk(
    input wire       I_CLK,
    input wire       I_RST,
    input wire       i_wr_en,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire [7:0] o_page,
    input wire       o_ramp_en,
    input wire       o_step_up,
    input wire       o_step_down,
    input wire       o_free_run,
    input wire       o_osc_mask,
    input wire       o_sync_mode
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    // off-page writes must not count
    wire w35 = i_wr_en && i_addr == 8'h35 && o_page == 8'h00;
    wire w37 = i_wr_en && i_addr == 8'h37 && o_page == 8'h00;
    a_step_up_pulse: assert property (w35 && i_wdata[3:2] == 2'h2 |=> o_step_up) else $error("up");
    a_step_down_pulse: assert property (w35 && i_wdata[3:2] == 2'h1 |=> o_step_down) else $error("dn");
    a_step_both_none: assert property (w35 && i_wdata[3:2] == 2'h3 |=> !o_step_up && !o_step_down)
        else $error("both");
    a_step_up_once: assert property (o_step_up && !(w35 && i_wdata[3:2] == 2'h2) |=> !o_step_up)
        else $error("up held");
    a_step_down_once: assert property (o_step_down && !(w35 && i_wdata[3:2] == 2'h1) |=> !o_step_down)
        else $error("dn held");
    a_free_run_wr: assert property (w35 |=> o_free_run == $past(i_wdata[1])) else $error("free");
    a_osc_mask_wr: assert property (w35 |=> o_osc_mask == $past(i_wdata[0])) else $error("mask");
    a_sync_mode_wr: assert property (w37 |=> o_sync_mode == $past(i_wdata[5])) else $error("sync");
    a_page_sel_wr: assert property (i_wr_en && i_addr == 8'hFF |=> o_page == $past(i_wdata))
        else $error("page");
    a_ramp_en_hold: assert property (!(i_wr_en && i_addr == 8'h30) |=> $stable(o_ramp_en)) else $error("ramp");
endmodule // pdrc_chk

// ---- sim/pdrc_host.sv ----
// host model driving the configuration strobes
// changes 1 ns after the rising clock edge
`timescale 1ns/1ps
module pdrc_host(
    input  wire       I_CLK,
    output reg        o_wr = 1'b0,
    output reg        o_rd = 1'b0,
    output reg  [7:0] o_a = 8'h00,
    output reg  [7:0] o_d = 8'h00
);
    // both step bits only when a test asks
    task op(input w, input [7:0] x, input [7:0] y);
    begin
        @(posedge I_CLK) #1;
        {o_wr, o_rd, o_a, o_d} = {w, !w, x, y};
        @(posedge I_CLK) #1;
        // released lines inverted so stale values never match
        {o_wr, o_rd, o_a, o_d} = {2'h0, ~x, ~y};
    end
    endtask
endmodule // pdrc_host

// ---- sim/pdrc_regs_bench.sv ----
// self-checking bench for the oscillator and ramp bank
// host model drives strobes; checker bound below
`timescale 1ns/1ps
module pdrc_regs_bench;
    reg         I_CLK = 1'b0;
    reg         I_RST = 1'b1;
    reg         rd_q = 1'b0;
    reg  [31:0] s = 32'h4E3FE4E1;
    reg  [7:0]  m [0:255];
    reg  [7:0]  q [$];
    integer     failures = 0;
    integer     compares = 0;
    integer     k;
    wire        wr, rd;
    wire        su, sd;
    wire [7:0]  a, d, rdat;
    wire [31:0] fr;
    wire [9:0]  ic;
    wire [5:0]  rc;
    pdrc_host host (.I_CLK(I_CLK), .o_wr(wr), .o_rd(rd), .o_a(a), .o_d(d));
    pdrc_regs dut (.I_CLK(I_CLK), .I_RST(I_RST), .i_wr_en(wr), .i_rd_en(rd), .i_addr(a), .i_wdata(d),
        .o_rdata(rdat), .o_page(), .o_ramp_en(rc[3]), .o_ramp_slope(rc[5:4]), .o_ramp_div(rc[2:0]),
        .o_frac_code(fr), .o_int_code(ic), .o_step_up(su), .o_step_down(sd), .o_free_run(), .o_osc_mask(),
        .o_sync_mode());
    always #5 I_CLK = ~I_CLK;
    function [31:0] xs(input [31:0] v);
    begin
        xs = v ^ (v << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    end
    endfunction
    task chk(input [31:0] g, input [31:0] e);
    begin
        compares = compares + 1;
        if (g !== e)
        begin
            failures = failures + 1;
            $display("Error %0t: got %h want %h", $time, g, e);
        end
    end
    endtask
    task wx(input [7:0] x, input [7:0] y);
    begin
        if (m[8'hFF] == 8'h00 || x == 8'hFF) m[x] = y;
        host.op(1'b1, x, y);
    end
    endtask
    task rx(input [7:0] x);
    begin
        // unmapped, reserved and off-page bits read zero
        q.push_back((m[8'hFF] != 8'h00 && x != 8'hFF) ? 8'h00 : m[x] & (x == 8'h30 ? 8'h3F :
            x == 8'h35 ? 8'h0F : (x > 8'h30 && x < 8'h38) || x == 8'hFF ? 8'hFF : 8'h00));
        host.op(1'b0, x, 8'h00);
    end
    endtask
    always @(posedge I_CLK)
    begin
        if (rd_q) chk(rdat, q.pop_front());
        rd_q <= rd;
    end
    task print_verdict;
    begin
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask
    initial
    begin
        #50000;
        failures = failures + 1;
        print_verdict;
    end
    initial
    begin
        for (k = 0; k < 256; k = k + 1) m[k] = 8'h00;
        repeat (16) @(posedge I_CLK);
        #1 I_RST = 1'b0;
        for (k = 8'h30; k < 8'h38; k = k + 1) rx(k);
        rx(8'hFF);
        for (k = 8'h30; k < 8'h38; k = k + 1)
        begin
            s = xs(s);
            // random step writes never ask both directions
            if (k == 8'h35 && s[3]) s[2] = 1'b0;
            wx(k, s[7:0]);
            rx(k);
        end
        chk(fr, {m[8'h34], m[8'h33], m[8'h32], m[8'h31]});
        chk(ic, {m[8'h36], m[8'h37][7:6]});
        chk(rc, m[8'h30][5:0]);
        rx(8'h40);
        wx(8'h35, 8'h08);
        chk({su, sd}, 2'h2);
        wx(8'h35, 8'h04);
        chk({su, sd}, 2'h1);
        wx(8'h35, 8'h0C);
        chk({su, sd}, 2'h0);
        rx(8'h35);
        wx(8'hFF, 8'h01);
        rx(8'h31);
        wx(8'h31, 8'h5A);
        rx(8'hFF);
        wx(8'hFF, 8'h00);
        rx(8'h31);
        repeat (4) @(posedge I_CLK);
        print_verdict;
    end
endmodule // pdrc_regs_bench
bind pdrc_regs pdrc_chk chk_i (
    .I_CLK      (I_CLK),
    .I_RST      (I_RST),
    .i_wr_en    (i_wr_en),
    .i_addr     (i_addr),
    .i_wdata    (i_wdata),
    .o_page     (o_page),
    .o_ramp_en  (o_ramp_en),
    .o_step_up  (o_step_up),
    .o_step_down(o_step_down),
    .o_free_run (o_free_run),
    .o_osc_mask (o_osc_mask),
    .o_sync_mode(o_sync_mode)
);
